// *** include/vsp_pkg.sv ***
// vsp_pkg: constants, states and carrier types for the valley switching pwm controller
// assumes a 250 MHz core clock; comparator levels arrive asynchronously from analog blocks
package vsp_pkg;
    localparam int unsigned CLK_MHZ = 250;
    // timing figures in their own units
    localparam int unsigned PERIOD_MS = 48;
    localparam int unsigned OVP_BLANK_US = 100;
    localparam int unsigned SW_BLANK_NS = 190;
    localparam int unsigned LEB_NS = 220;
    localparam int unsigned SHORT_SUPP_NS = 2500;
    localparam int unsigned LONG_SUPP_NS = 25000;
    localparam int unsigned MAX_OFF_US = 42;
    localparam int unsigned MAX_ON_US = 22;
    // cycle counts: least times round up, longest times round down
    localparam int unsigned PERIOD_CYC = PERIOD_MS * CLK_MHZ * 1000;
    localparam int unsigned OVP_BLANK_CYC = OVP_BLANK_US * CLK_MHZ;
    localparam int unsigned SW_BLANK_CYC = (SW_BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned LEB_CYC = (LEB_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SHORT_SUPP_CYC = (SHORT_SUPP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned LONG_SUPP_CYC = (LONG_SUPP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned MAX_OFF_CYC = MAX_OFF_US * CLK_MHZ;
    localparam int unsigned MAX_ON_CYC = MAX_ON_US * CLK_MHZ;
    localparam int unsigned TMR_W = 24;
    localparam int unsigned PER_W = 24;

    localparam logic [2:0] VALLEY_MIN = 3'h1;
    localparam logic [2:0] VALLEY_MAX = 3'h7;
    localparam logic [2:0] CROSS_MAX = 3'h7;
    localparam logic [2:0] CROSS_RST = 3'h0;

    typedef enum logic [1:0] {
        VSP_OFF_SUPP,
        VSP_OFF_WAIT,
        VSP_ON,
        VSP_LATCHED
    } vsp_state_t;

    // comparator results from the analog front end
    typedef struct packed {
        logic fb_above_low;
        logic fb_above_high;
        logic fb_above_reset;
        logic aux_below_crossing;
        logic aux_above_ovp;
        logic aux_below_supp_sel;
        logic sense_above_fb;
        logic sense_above_limit;
        logic sense_above_short;
    } vsp_cmp_t;

    // observable status
    typedef struct packed {
        logic [2:0] valley_count;
        logic [2:0] crossing_count;
        logic ovp_latch;
        logic short_latch;
    } vsp_status_t;
endpackage

// *** rtl/vsp_ctrl.sv ***
// vsp_ctrl: quasi-resonant valley switching gate controller with latch-off protection
// assumes analog comparator outputs on cmp_in and arst_n tied to the power-down reset
// What this block does
// RULE_01: judge feedback every 48 ms, update valley count
// RULE_02: feedback always low: increment valley count, max 7
// RULE_03: above low but not high: hold count
// RULE_04: above high not reset: decrement, min 1
// RULE_05: above reset threshold: force valley count to 1
// RULE_06: valley count stays 1..7, never wraps
// RULE_07: valley count starts at 1
// RULE_08: count falling aux crossings after switch-off, 0..7
// RULE_09: clear crossing count when gate rises
// RULE_10: persistent off-time overvoltage latches gate off
// RULE_11: low aux picks long suppression, else short
// RULE_12: no turn-on during ringing suppression
// RULE_13: turn on when crossings reach valley count
// RULE_14: turn on after maximum off time regardless
// RULE_15: sense above feedback turns gate off
// RULE_16: blank current comparators after turn-on
// RULE_17: turn off after maximum on time
// RULE_18: current limit turns gate off at once
// RULE_19: short-winding latch needs persistent assertion
// RULE_20: overvoltage blanking 100 us before latch
// RULE_21: short-winding blanking 190 ns before latch
// RULE_22: latch cleared only by power-down reset
// RULE_23: synchronise inputs, time everything by counters
`timescale 1ns/1ps
`default_nettype none
module vsp_ctrl
    import vsp_pkg::*;
#(
    parameter int unsigned PERIOD_CYCLES = PERIOD_CYC,
    parameter int unsigned OVP_CYCLES = OVP_BLANK_CYC,
    parameter int unsigned LONG_SUPP_CYCLES = LONG_SUPP_CYC,
    parameter int unsigned MAX_OFF_CYCLES = MAX_OFF_CYC,
    parameter int unsigned MAX_ON_CYCLES = MAX_ON_CYC
) (
    // clock and power-down reset
    input wire logic clk,
    input wire logic arst_n,
    // analog comparator results
    input wire vsp_pkg::vsp_cmp_t cmp_in,
    // gate and status
    output logic gate_drive_output,
    output logic latch_off,
    output vsp_pkg::vsp_status_t status
);
    import vsp_pkg::*;

    // parameter values that the counters cannot serve are refused
    initial begin
        if (PER_W > 31 || TMR_W > 31) begin
            $error("vsp_ctrl: counter width too large");
        end
        if (PERIOD_CYCLES < 2 || PERIOD_CYCLES >= (1 << PER_W)) begin
            $error("vsp_ctrl: PERIOD_CYCLES out of range");
        end
        if (OVP_CYCLES < 1 || OVP_CYCLES >= (1 << TMR_W)) begin
            $error("vsp_ctrl: overvoltage blanking count out of range");
        end
        if (LONG_SUPP_CYCLES >= (1 << TMR_W)) begin
            $error("vsp_ctrl: long suppression count out of range");
        end
        if (SHORT_SUPP_CYC < 1 || SHORT_SUPP_CYC > LONG_SUPP_CYCLES) begin
            $error("vsp_ctrl: short suppression must not exceed the long one");
        end
        if (SW_BLANK_CYC < 1 || SW_BLANK_CYC >= MAX_ON_CYCLES) begin
            $error("vsp_ctrl: short-winding blanking must fit the on time");
        end
        if (LEB_CYC < 1) begin
            $error("vsp_ctrl: leading edge blanking must be at least one cycle");
        end
        if (MAX_OFF_CYCLES <= LONG_SUPP_CYCLES || MAX_OFF_CYCLES >= (1 << TMR_W)) begin
            $error("vsp_ctrl: MAX_OFF_CYCLES must exceed suppression and fit the timer");
        end
        if (MAX_ON_CYCLES <= LEB_CYC || MAX_ON_CYCLES >= (1 << TMR_W)) begin
            $error("vsp_ctrl: MAX_ON_CYCLES must exceed blanking and fit the timer");
        end
    end

    localparam logic [PER_W-1:0] PER_LAST = PER_W'(PERIOD_CYCLES - 1);
    localparam logic [TMR_W-1:0] OVP_N = TMR_W'(OVP_CYCLES);
    localparam logic [TMR_W-1:0] SW_N = TMR_W'(SW_BLANK_CYC);
    localparam logic [TMR_W-1:0] LEB_N = TMR_W'(LEB_CYC);
    localparam logic [TMR_W-1:0] SUPP_S_N = TMR_W'(SHORT_SUPP_CYC);
    localparam logic [TMR_W-1:0] SUPP_L_N = TMR_W'(LONG_SUPP_CYCLES);
    localparam logic [TMR_W-1:0] OFF_N = TMR_W'(MAX_OFF_CYCLES);
    localparam logic [TMR_W-1:0] ON_N = TMR_W'(MAX_ON_CYCLES);

    typedef struct packed {
        vsp_cmp_t sync1;
        vsp_cmp_t sync2;
        logic aux_low_prev;
        vsp_state_t state;
        logic gate;
        logic [PER_W-1:0] period_cnt;
        logic seen_low;
        logic seen_high;
        logic [2:0] valley;
        logic [2:0] crossing;
        logic [TMR_W-1:0] phase_tmr;
        logic [TMR_W-1:0] supp_len;
        logic [TMR_W-1:0] ovp_tmr;
        logic [TMR_W-1:0] sw_tmr;
        logic ovp_latch;
        logic short_latch;
    } vsp_regs_t;

    localparam vsp_regs_t REGS_RST = '{
        sync1: '0,
        sync2: '0,
        aux_low_prev: 1'b0,
        state: VSP_OFF_SUPP,
        gate: 1'b0,
        period_cnt: '0,
        seen_low: 1'b0,
        seen_high: 1'b0,
        valley: VALLEY_MIN,
        crossing: CROSS_RST,
        phase_tmr: '0,
        supp_len: SUPP_S_N,
        ovp_tmr: '0,
        sw_tmr: '0,
        ovp_latch: 1'b0,
        short_latch: 1'b0
    };

    vsp_regs_t r;
    vsp_regs_t next_r;

    // saturating timer step
    function automatic logic [TMR_W-1:0] tick(input logic [TMR_W-1:0] t);
        return (&t) ? t : t + TMR_W'(1);
    endfunction

    // true when the count reaches n on the coming edge; the extra bit keeps a saturated timer from wrapping
    function automatic logic reached(input logic [TMR_W-1:0] t, input logic [TMR_W-1:0] n);
        logic [TMR_W:0] nxt;
        nxt = {1'b0, t} + {{TMR_W{1'b0}}, 1'b1};
        return nxt >= {1'b0, n};
    endfunction

    // persistence timer: counts while the condition stands, restarts once it drops
    function automatic logic [TMR_W-1:0] persist(input logic [TMR_W-1:0] t, input logic active);
        logic [TMR_W-1:0] res;
        res = '0;
        if (active) begin
            res = tick(t);
        end
        return res;
    endfunction

    // crossing counter step; ringing beyond the top count is ignored
    function automatic logic [2:0] cross_step(input logic [2:0] cnt, input logic fall);
        logic [2:0] res;
        res = cnt;
        if (fall && cnt != CROSS_MAX) begin
            res = cnt + 3'h1; // see RULE_08
        end
        return res;
    endfunction

    // valley count at a period end: up when feedback stayed low, down after a high excursion
    function automatic logic [2:0] valley_step(input logic [2:0] v, input logic any_low, input logic any_high);
        logic [2:0] res;
        res = v;
        if (!any_low) begin
            if (v != VALLEY_MAX) begin
                res = v + 3'h1; // see RULE_02 RULE_06
            end
        end else if (any_high) begin
            if (v != VALLEY_MIN) begin
                res = v - 3'h1; // see RULE_04 RULE_06
            end
        end
        // otherwise the count holds, see RULE_03
        return res;
    endfunction

    // suppression length picked at switch-off from the aux level
    function automatic logic [TMR_W-1:0] supp_pick(input logic aux_low);
        return aux_low ? SUPP_L_N : SUPP_S_N; // see RULE_11
    endfunction

    // the off phase spans suppression and waiting; the latched state is not part of it
    function automatic logic in_off(input vsp_state_t s);
        return (s == VSP_OFF_SUPP) || (s == VSP_OFF_WAIT);
    endfunction

    always_comb begin
        vsp_cmp_t c;
        logic end_period;
        logic fall_cross;
        logic turn_on;
        logic turn_off;
        logic blanked;
        logic any_low;
        logic any_high;
        logic ovp_active;
        logic short_active;

        c = '0;
        end_period = 1'b0;
        fall_cross = 1'b0;
        turn_on = 1'b0;
        turn_off = 1'b0;
        blanked = 1'b0;
        any_low = 1'b0;
        any_high = 1'b0;
        ovp_active = 1'b0;
        short_active = 1'b0;
        next_r = r;
        c = r.sync2;

        // two-stage synchronisers on every comparator; only sync2 feeds the logic
        next_r.sync1 = cmp_in; // see RULE_23
        next_r.sync2 = r.sync1;
        next_r.aux_low_prev = c.aux_below_crossing;

        // load evaluation period; the last cycle's sample still counts toward the verdict
        end_period = (r.period_cnt == PER_LAST); // see RULE_01
        next_r.period_cnt = end_period ? '0 : r.period_cnt + PER_W'(1);
        any_low = r.seen_low | c.fb_above_low;
        any_high = r.seen_high | c.fb_above_high;
        next_r.seen_low = end_period ? 1'b0 : any_low;
        next_r.seen_high = end_period ? 1'b0 : any_high;
        if (c.fb_above_reset) begin
            // a load step must not wait for the period end
            next_r.valley = VALLEY_MIN; // see RULE_05
        end else if (end_period) begin
            next_r.valley = valley_step(r.valley, any_low, any_high); // see RULE_01
        end
        // a corrupted count falls back to the fastest rate rather than stalling at zero
        if (next_r.valley < VALLEY_MIN) begin
            next_r.valley = VALLEY_MIN; // see RULE_06
        end

        // falling crossing detection on the aux sense
        fall_cross = c.aux_below_crossing && !r.aux_low_prev;
        // current comparators are ignored for the first cycles of each on phase
        blanked = (r.phase_tmr < LEB_N); // see RULE_16

        case (r.state)
            VSP_OFF_SUPP: begin
                next_r.phase_tmr = tick(r.phase_tmr);
                next_r.crossing = cross_step(r.crossing, fall_cross); // see RULE_08
                // ringing is still counted, but no turn-on is taken here
                if (reached(r.phase_tmr, r.supp_len)) begin
                    next_r.state = VSP_OFF_WAIT; // see RULE_12
                end
            end
            VSP_OFF_WAIT: begin
                next_r.phase_tmr = tick(r.phase_tmr);
                next_r.crossing = cross_step(r.crossing, fall_cross); // see RULE_08
                if (r.crossing >= r.valley) begin
                    turn_on = 1'b1; // see RULE_13
                end
                // the off timer runs from switch-off, so suppression time counts toward it
                if (reached(r.phase_tmr, OFF_N)) begin
                    turn_on = 1'b1; // see RULE_14
                end
            end
            VSP_ON: begin
                next_r.phase_tmr = tick(r.phase_tmr);
                // either current comparator ends the on phase once blanking is over
                if (!blanked && (c.sense_above_fb || c.sense_above_limit)) begin
                    turn_off = 1'b1; // see RULE_15 RULE_16 RULE_18
                end
                if (reached(r.phase_tmr, ON_N)) begin
                    turn_off = 1'b1; // see RULE_17
                end
            end
            VSP_LATCHED: begin
                // only the power-down reset leaves this state
                next_r.gate = 1'b0;
            end
            default: begin
                // an illegal state is treated as a fault and holds the gate low
                next_r.state = VSP_LATCHED;
                next_r.gate = 1'b0;
            end
        endcase

        // switch-on restarts the phase timer and the crossing count
        if (turn_on) begin
            next_r.state = VSP_ON;
            next_r.gate = 1'b1;
            next_r.phase_tmr = '0;
            next_r.crossing = CROSS_RST; // see RULE_09
        end

        // switch-off restarts the phase timer for suppression and the off limit
        if (turn_off) begin
            next_r.state = VSP_OFF_SUPP;
            next_r.gate = 1'b0;
            next_r.phase_tmr = '0;
            next_r.supp_len = supp_pick(c.aux_below_supp_sel); // see RULE_11
        end

        // output overvoltage during off-time, persistence blanked
        ovp_active = c.aux_above_ovp && !r.gate && in_off(r.state);
        next_r.ovp_tmr = persist(r.ovp_tmr, ovp_active);
        if (ovp_active && reached(r.ovp_tmr, OVP_N)) begin
            next_r.ovp_latch = 1'b1; // see RULE_10 RULE_20
        end

        // short winding during on-time, spike blanked so a turn-on spike cannot latch
        short_active = c.sense_above_short && r.gate;
        next_r.sw_tmr = persist(r.sw_tmr, short_active);
        if (short_active && reached(r.sw_tmr, SW_N)) begin
            next_r.short_latch = 1'b1; // see RULE_19 RULE_21
        end

        // latch holds until the power-down reset; nothing else clears it
        if (next_r.ovp_latch || next_r.short_latch) begin
            next_r.state = VSP_LATCHED; // see RULE_22
            next_r.gate = 1'b0;
        end
    end

    // the power-down reset returns every register to its start-up value
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= REGS_RST; // see RULE_07 RULE_22
        end else begin
            r <= next_r;
        end
    end

    assign gate_drive_output = r.gate;
    assign latch_off = r.ovp_latch | r.short_latch;
    assign status = '{
        valley_count: r.valley,
        crossing_count: r.crossing,
        ovp_latch: r.ovp_latch,
        short_latch: r.short_latch
    };
endmodule
`default_nettype wire

// *** test/vsp_ctrl_monitor.sv ***
// vsp_ctrl_monitor: port-level timing checks for the valley switching controller
// assumes a bind onto vsp_ctrl with the same shortened counts
`timescale 1ns/1ps
`default_nettype none
module vsp_ctrl_monitor
    import vsp_pkg::*;
#(
    parameter int unsigned MAX_OFF_CYCLES = MAX_OFF_CYC,
    parameter int unsigned MAX_ON_CYCLES = MAX_ON_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // watched ports
    input wire vsp_pkg::vsp_cmp_t cmp_in,
    input wire logic gate_drive_output,
    input wire logic latch_off,
    input wire vsp_pkg::vsp_status_t status
);
    logic [15:0] off_cnt;
    logic [15:0] on_cnt;
    // length of the current off and on phases
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            off_cnt <= '0;
            on_cnt <= '0;
        end else begin
            off_cnt <= gate_drive_output ? 16'h0000 : off_cnt + 16'h0001;
            on_cnt <= gate_drive_output ? on_cnt + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_supp_hold: assert property ($rose(gate_drive_output) |-> off_cnt >= 16'd624)
        else $error("gate on inside suppression");
    a_max_off: assert property (!gate_drive_output && !latch_off |-> off_cnt <= MAX_OFF_CYCLES + 3)
        else $error("off time too long");
    a_turn_on_cause: assert property ($rose(gate_drive_output) |->
        $past(status.crossing_count) >= $past(status.valley_count) || off_cnt >= MAX_OFF_CYCLES - 3)
        else $error("gate on without cause");
    a_leb_min: assert property ($fell(gate_drive_output) |-> (on_cnt >= 16'd55) or (##[0:2] latch_off))
        else $error("on time below blanking");
    a_max_on: assert property (gate_drive_output |-> on_cnt <= MAX_ON_CYCLES + 2)
        else $error("on time too long");
    a_cross_clear: assert property ($rose(gate_drive_output) |-> status.crossing_count == 3'h0)
        else $error("crossing count not cleared");
    a_latch_hold: assert property (latch_off |=> latch_off && !gate_drive_output)
        else $error("latch released");
    a_valley_range: assert property (status.valley_count != 3'h0)
        else $error("valley count out of range");
    a_valley_force: assert property (cmp_in.fb_above_reset [*3] |-> ##[0:3] status.valley_count == 3'h1)
        else $error("valley count not forced");
    a_valley_step: assert property ($changed(status.valley_count) |-> status.valley_count == 3'h1 ||
        status.valley_count == $past(status.valley_count) + 3'h1 ||
        status.valley_count == $past(status.valley_count) - 3'h1)
        else $error("valley count jumped");
    c_latch: cover property ($rose(latch_off));
    c_max_off: cover property ($rose(gate_drive_output) && off_cnt >= 16'd990);
    c_valley_top: cover property (status.valley_count == 3'h7);
endmodule
`default_nettype wire

// *** test/vsp_far_side.sv ***
// vsp_far_side: comparator levels of the flyback stage around the controller
// assumes the bench sets the knobs at the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module vsp_far_side
    import vsp_pkg::*;
(
    // clock and gate
    input wire logic clk,
    input wire logic gate,
    // bench knobs
    input wire logic [2:0] fb_lvl,
    input wire logic [3:0] ring_n,
    input wire logic [7:0] ramp,
    input wire logic supp_sel,
    input wire logic ovp,
    input wire logic shrt,
    // comparator levels
    output var vsp_pkg::vsp_cmp_t cmp
);
    int t_off = 0;
    int t_on = 0;
    always @(posedge clk) begin
        t_off <= gate ? 0 : t_off + 1;
        t_on <= gate ? t_on + 1 : 0;
    end
    always_comb begin
        cmp = '0;
        {cmp.fb_above_reset, cmp.fb_above_high, cmp.fb_above_low} = fb_lvl;
        // ringing: ring_n crossings, one every 20 cycles
        cmp.aux_below_crossing = !gate && t_off >= 10 && (t_off - 10) % 20 < 5 && (t_off - 10) / 20 < ring_n;
        cmp.aux_below_supp_sel = supp_sel;
        cmp.aux_above_ovp = ovp && !gate;
        cmp.sense_above_fb = gate && t_on >= ramp;
        cmp.sense_above_limit = gate && t_on >= 90;
        cmp.sense_above_short = shrt && gate;
    end
endmodule
`default_nettype wire

// *** test/valley_switching_pwm_control_test.sv ***
// valley_switching_pwm_control_test: random and corner stimulus for vsp_ctrl
// assumes vsp_pkg, vsp_far_side and vsp_ctrl_monitor compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module valley_switching_pwm_control_test;
    import vsp_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    vsp_cmp_t cmp_in;
    logic gate_drive_output;
    logic latch_off;
    vsp_status_t status;
    logic [2:0] fb_lvl, v_exp, seen;
    logic [3:0] ring_n;
    logic [7:0] ramp;
    logic supp_sel, ovp, shrt;
    int err_count = 0;
    int compares = 0;
    int cyc, n, lo, pick;
    always #2 clk = ~clk;
    vsp_ctrl #(.PERIOD_CYCLES(200), .OVP_CYCLES(20), .LONG_SUPP_CYCLES(800), .MAX_OFF_CYCLES(1000),
        .MAX_ON_CYCLES(120)) i_vsp_ctrl (.clk(clk), .arst_n(arst_n), .cmp_in(cmp_in),
        .gate_drive_output(gate_drive_output), .latch_off(latch_off), .status(status));
    vsp_far_side i_vsp_far_side (.clk(clk), .gate(gate_drive_output), .fb_lvl(fb_lvl), .ring_n(ring_n),
        .ramp(ramp), .supp_sel(supp_sel), .ovp(ovp), .shrt(shrt), .cmp(cmp_in));
    task automatic finish_test();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wait_lvl(input logic v);
        int k;
        k = 0;
        while (gate_drive_output !== v && k < 3000) begin @(negedge clk); k++; end
        if (k == 3000) begin err_count++; finish_test(); end
    endtask
    task automatic do_reset();
        arst_n = 1'b0;
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
    endtask
    // feedback levels per period and the expected valley count
    always @(negedge clk or negedge arst_n) begin
        if (!arst_n) begin cyc = 0; v_exp = 3'h1; seen = 3'h0; fb_lvl <= 3'h0; end
        else begin
            cyc++;
            seen = seen | fb_lvl;
            if (cyc % 200 == 0) begin
                if (seen[2]) v_exp = 3'h1;
                else if (!seen[0] && v_exp != 3'h7) v_exp++;
                else if (seen[1] && v_exp != 3'h1) v_exp--;
                seen = fb_lvl;
            end
            if (cyc % 200 == 100) begin
                `CHK(status.valley_count, v_exp)
                pick = $urandom_range(0, 3);
                fb_lvl <= cyc < 1800 ? 3'h0 : cyc < 3600 ? 3'h3 : 3'(3'h7 >> (3 - pick));
            end
        end
    end
    initial begin
        {ring_n, ramp, supp_sel, ovp, shrt} = '0;
        void'($urandom(18270));
        @(negedge clk);
        do_reset();
        @(negedge clk);
        `CHK({gate_drive_output, latch_off, status}, 10'h020)
        for (int i = 0; i < 12; i++) begin
            ramp = 8'($urandom_range(0, 150));
            supp_sel = i[0];
            ring_n = i[1] ? 4'h0 : 4'h8;
            wait_lvl(1'b1);
            wait_lvl(1'b0);
            n = 0;
            while (gate_drive_output === 1'b0 && n < 2000) begin
                @(negedge clk);
                n++;
                if (n == 600) `CHK(status.crossing_count, i[1] ? 3'h0 : 3'h7)
            end
            if (n == 2000) begin err_count++; finish_test(); end
            lo = i[1] ? 996 : i[0] ? 797 : 622;
            `CHK(n >= lo && n <= lo + 10, 1'b1)
            `CHK(status.crossing_count, 3'h0)
        end
        wait_lvl(1'b0);
        ovp = 1'b1;
        repeat (10) @(negedge clk);
        ovp = 1'b0;
        repeat (5) @(negedge clk);
        `CHK(latch_off, 1'b0)
        ovp = 1'b1;
        repeat (30) @(negedge clk);
        `CHK({latch_off, status.ovp_latch}, 2'h3)
        ovp = 1'b0;
        repeat (1500) @(negedge clk);
        `CHK({gate_drive_output, latch_off}, 2'h1)
        do_reset();
        `CHK(latch_off, 1'b0)
        shrt = 1'b1;
        ramp = 8'hff;
        wait_lvl(1'b1);
        repeat (70) @(negedge clk);
        `CHK({gate_drive_output, status.short_latch}, 2'h1)
        finish_test();
    end
endmodule
bind vsp_ctrl vsp_ctrl_monitor #(.MAX_OFF_CYCLES(MAX_OFF_CYCLES), .MAX_ON_CYCLES(MAX_ON_CYCLES)) i_vsp_ctrl_monitor (
    .clk(clk), .arst_n(arst_n), .cmp_in(cmp_in), .gate_drive_output(gate_drive_output), .latch_off(latch_off),
    .status(status));
`default_nettype wire
